// File: core/qdac_pkg.sv
// Constants shared by the quad converter serial command control
package qdac_pkg;
   localparam int WORD_W = 16;
   localparam int CODE_W = 10;
   localparam int NUM_CH = 4;
   localparam int SYNC_W = 2;
   // Field positions inside the command word, most significant bit first
   localparam int ADDR_HI = 15;
   localparam int ADDR_LO = 14;
   localparam int CTRL_HI = 13;
   localparam int CTRL_LO = 12;
   localparam int OP_HI = 15;
   localparam int OP_LO = 12;
   localparam int CODE_HI = 11;
   localparam int CODE_LO = 2;
   localparam int SUB_HI = 1;
   localparam int SUB_LO = 0;
   // Control bit pairs that load an input register
   localparam logic [1:0] CTRL_LOAD = 2'h1;
   localparam logic [1:0] CTRL_LOAD_XFER = 2'h3;
   // Full address/control codes
   localparam logic [3:0] OP_NO_OPERATION = 4'h0;
   localparam logic [3:0] OP_UPO_LOW = 4'h2;
   localparam logic [3:0] OP_UPDATE_WAKE = 4'h4;
   localparam logic [3:0] OP_UPO_HIGH = 4'h6;
   localparam logic [3:0] OP_LOAD_ALL = 4'h8;
   localparam logic [3:0] OP_MODE0 = 4'ha;
   localparam logic [3:0] OP_SHUTDOWN = 4'hc;
   localparam logic [3:0] OP_MODE1 = 4'he;
   // Values after reset
   localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
   localparam logic MODE_RESET = 1'h0;
   localparam logic UPO_RESET = 1'h0;
   localparam logic SHUTDOWN_RESET = 1'h0;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 2'h3;
endpackage

// File: core/bit_sync.sv
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/100ps
module bit_sync #(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule

// File: core/word_shifter.sv
// Serial-clock side: sixteen-bit shift register and echo output
`timescale 1ns/100ps
module word_shifter #(
   parameter int WIDTH = 16
) (
   input wire logic sclk,
   input wire logic clear_n,
   input wire logic cs_n,
   input wire logic din,
   input wire logic echo_mode,
   output logic [WIDTH-1:0] word,
   output logic dout
);
   logic [WIDTH-1:0] shift_reg;
   logic rise_reg;
   logic fall_reg;
   logic mode_meta_reg;
   logic mode_sync_reg;

   // Clock is ignored while chip select is high
   always_ff @(posedge sclk or negedge clear_n) begin
      if (!clear_n) begin
         shift_reg <= '0;
         rise_reg <= 1'h0;
      end else if (!cs_n) begin
         shift_reg <= {shift_reg[WIDTH-2:0], din};
         rise_reg <= shift_reg[WIDTH-1];
      end
   end

   // Half-cycle later copy gives the falling-edge echo
   always_ff @(negedge sclk or negedge clear_n) begin
      if (!clear_n) begin
         fall_reg <= 1'h0;
      end else begin
         fall_reg <= rise_reg;
      end
   end

   // Mode is a slow level; it settles only while the link clock runs
   always_ff @(posedge sclk or negedge clear_n) begin
      if (!clear_n) begin
         mode_meta_reg <= qdac_pkg::MODE_RESET;
         mode_sync_reg <= qdac_pkg::MODE_RESET;
      end else begin
         mode_meta_reg <= echo_mode;
         mode_sync_reg <= mode_meta_reg;
      end
   end

   assign word = shift_reg;
   assign dout = mode_sync_reg ? rise_reg : fall_reg;
endmodule

// File: core/quad_dac_serial_command_control.sv
// Command decode and double-buffered registers of a quad 10-bit converter
//
// How it works
// - One sixteen-bit shift register takes serial input and feeds the echo.
// - Each of four channels holds an input register then a converter register.
// - Word: two address, two control, ten code bits, two sub-bits, MSB first.
// - Control 01 loads the addressed input register only.
// - Control 11 loads the addressed input register, then updates every channel.
// - Code 0100 updates every converter register and leaves shutdown.
// - Code 1000 loads all channels with the word's code and leaves shutdown.
// - Code 1100 enters shutdown only while lockout input is high.
// - Code 0010 drives logic output low, 0110 drives it high.
// - Code 0000 changes no register.
// - Code 1110 selects rising-edge echo and updates every converter register.
// - Code 1010 selects falling-edge echo and updates every converter register.
// - Shutdown keeps port active and input registers intact for wake.
// - Shift register contents appear on the echo output.
// - Shift on rising clock with select low; act on select rising.
// - Echo lags input by 16.5 cycles in mode 0, 16 in mode 1.
// - Reset clears all channel registers and selects echo mode 0.
// - Lockout falling while shut down wakes the device asynchronously.
`timescale 1ns/100ps
module quad_dac_serial_command_control #(
   parameter int NUM_CH = qdac_pkg::NUM_CH,
   parameter int CODE_W = qdac_pkg::CODE_W
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic clear_n,
   input wire logic shutdown_lockout_n,
   output logic dout,
   output logic [CODE_W-1:0] conv_a,
   output logic [CODE_W-1:0] conv_b,
   output logic [CODE_W-1:0] conv_c,
   output logic [CODE_W-1:0] conv_d,
   output logic user_logic_out,
   output logic shutdown,
   output logic echo_mode
);

////////////////////////////////////////////////////////////////////////
   // Link side

   logic [qdac_pkg::WORD_W-1:0] link_word;
   logic echo_mode_reg;

   word_shifter #(
      .WIDTH(qdac_pkg::WORD_W)
   ) u_shifter (
      .sclk(sclk),
      .clear_n(clear_n),
      .cs_n(cs_n),
      .din(din),
      .echo_mode(echo_mode_reg),
      .word(link_word),
      .dout(dout)
   );

////////////////////////////////////////////////////////////////////////
   // Crossing of select and lockout

   logic [qdac_pkg::SYNC_W-1:0] sync_bits;
   logic cs_sync;
   logic lock_sync;
   logic cs_prev_reg;
   logic cs_rise;

   bit_sync #(
      .WIDTH(qdac_pkg::SYNC_W),
      .INIT(qdac_pkg::SYNC_RESET)
   ) u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .async_in({cs_n, shutdown_lockout_n}),
      .sync_out(sync_bits)
   );

   assign cs_sync = sync_bits[1];
   assign lock_sync = sync_bits[0];
   assign cs_rise = cs_sync & ~cs_prev_reg;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cs_prev_reg <= 1'h1;
      end else begin
         cs_prev_reg <= cs_sync;
      end
   end

////////////////////////////////////////////////////////////////////////
   // Word capture

   logic [qdac_pkg::WORD_W-1:0] word_reg;
   logic cmd_valid_reg;

   // Shift register is quiet here: it ignores the link clock while select is high
   always_ff @(posedge clk_sys or negedge clear_n) begin
      if (!clear_n) begin
         word_reg <= '0;
         cmd_valid_reg <= 1'h0;
      end else if (!nrst) begin
         word_reg <= '0;
         cmd_valid_reg <= 1'h0;
      end else begin
         cmd_valid_reg <= cs_rise;
         if (cs_rise) begin
            word_reg <= link_word;
         end
      end
   end

////////////////////////////////////////////////////////////////////////
   // Decode

   logic [1:0] cmd_addr;
   logic [1:0] cmd_ctrl;
   logic [3:0] cmd_op;
   logic [CODE_W-1:0] cmd_code;
   logic do_load;
   logic do_xfer;
   logic do_bcast;
   logic do_wake;
   logic do_sleep;
   logic do_upo_low;
   logic do_upo_high;
   logic do_mode0;
   logic do_mode1;

   assign cmd_addr = word_reg[qdac_pkg::ADDR_HI:qdac_pkg::ADDR_LO];
   assign cmd_ctrl = word_reg[qdac_pkg::CTRL_HI:qdac_pkg::CTRL_LO];
   assign cmd_op = word_reg[qdac_pkg::OP_HI:qdac_pkg::OP_LO];
   // Sub-bits are not used; a nonzero pair is simply dropped
   assign cmd_code = word_reg[qdac_pkg::CODE_HI:qdac_pkg::CODE_LO];

   assign do_load = cmd_valid_reg & ((cmd_ctrl == qdac_pkg::CTRL_LOAD)
                    | (cmd_ctrl == qdac_pkg::CTRL_LOAD_XFER));
   assign do_xfer = cmd_valid_reg & ((cmd_ctrl == qdac_pkg::CTRL_LOAD_XFER)
                    | (cmd_op == qdac_pkg::OP_UPDATE_WAKE)
                    | (cmd_op == qdac_pkg::OP_MODE0)
                    | (cmd_op == qdac_pkg::OP_MODE1));
   assign do_bcast = cmd_valid_reg & (cmd_op == qdac_pkg::OP_LOAD_ALL);
   assign do_wake = cmd_valid_reg & ((cmd_op == qdac_pkg::OP_UPDATE_WAKE)
                    | (cmd_op == qdac_pkg::OP_LOAD_ALL));
   assign do_sleep = cmd_valid_reg & (cmd_op == qdac_pkg::OP_SHUTDOWN) & lock_sync;
   assign do_upo_low = cmd_valid_reg & (cmd_op == qdac_pkg::OP_UPO_LOW);
   assign do_upo_high = cmd_valid_reg & (cmd_op == qdac_pkg::OP_UPO_HIGH);
   assign do_mode0 = cmd_valid_reg & (cmd_op == qdac_pkg::OP_MODE0);
   assign do_mode1 = cmd_valid_reg & (cmd_op == qdac_pkg::OP_MODE1);

////////////////////////////////////////////////////////////////////////
   // Channel registers

   logic [CODE_W-1:0] input_reg [NUM_CH];
   logic [CODE_W-1:0] input_next [NUM_CH];
   logic [CODE_W-1:0] conv_reg [NUM_CH];
   logic [CODE_W-1:0] conv_next [NUM_CH];
   // Packed copies so the checks can take past values of whole banks
   logic [NUM_CH*CODE_W-1:0] input_flat;
   logic [NUM_CH*CODE_W-1:0] conv_flat;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         logic hit;
         // Code 0000 and codes 0010, 0110 and 1100 leave both stages alone
         assign hit = do_load & (cmd_addr == 2'(ch));
         assign input_next[ch] = (hit | do_bcast) ? cmd_code : input_reg[ch];
         // Transfer uses the freshly loaded value for the addressed channel
         assign conv_next[ch] = do_bcast ? cmd_code :
                                do_xfer ? input_next[ch] : conv_reg[ch];
         assign input_flat[ch*CODE_W +: CODE_W] = input_reg[ch];
         assign conv_flat[ch*CODE_W +: CODE_W] = conv_reg[ch];

         always_ff @(posedge clk_sys or negedge clear_n) begin
            if (!clear_n) begin
               input_reg[ch] <= qdac_pkg::CODE_RESET;
               conv_reg[ch] <= qdac_pkg::CODE_RESET;
            end else if (!nrst) begin
               input_reg[ch] <= qdac_pkg::CODE_RESET;
               conv_reg[ch] <= qdac_pkg::CODE_RESET;
            end else begin
               input_reg[ch] <= input_next[ch];
               conv_reg[ch] <= conv_next[ch];
            end
         end
      end
   endgenerate

   assign conv_a = conv_reg[0];
   assign conv_b = conv_reg[1];
   assign conv_c = conv_reg[2];
   assign conv_d = conv_reg[3];

////////////////////////////////////////////////////////////////////////
   // Logic output and echo mode

   logic upo_reg;

   always_ff @(posedge clk_sys or negedge clear_n) begin
      if (!clear_n) begin
         upo_reg <= qdac_pkg::UPO_RESET;
         echo_mode_reg <= qdac_pkg::MODE_RESET;
      end else if (!nrst) begin
         upo_reg <= qdac_pkg::UPO_RESET;
         echo_mode_reg <= qdac_pkg::MODE_RESET;
      end else begin
         if (do_upo_high) begin
            upo_reg <= 1'h1;
         end else if (do_upo_low) begin
            upo_reg <= 1'h0;
         end
         if (do_mode1) begin
            echo_mode_reg <= 1'h1;
         end else if (do_mode0) begin
            echo_mode_reg <= 1'h0;
         end
      end
   end

   assign user_logic_out = upo_reg;
   assign echo_mode = echo_mode_reg;

////////////////////////////////////////////////////////////////////////
   // Shutdown

   logic shutdown_reg;

   // Lockout pin clears this flop directly, so waking needs no clock
   always_ff @(posedge clk_sys or negedge clear_n or negedge shutdown_lockout_n) begin
      if (!clear_n) begin
         shutdown_reg <= qdac_pkg::SHUTDOWN_RESET;
      end else if (!shutdown_lockout_n) begin
         shutdown_reg <= qdac_pkg::SHUTDOWN_RESET;
      end else if (!nrst) begin
         shutdown_reg <= qdac_pkg::SHUTDOWN_RESET;
      end else if (do_sleep) begin
         shutdown_reg <= 1'h1;
      end else if (do_wake) begin
         shutdown_reg <= 1'h0;
      end
   end

   assign shutdown = shutdown_reg;

////////////////////////////////////////////////////////////////////////
   // Checks

   property p_cs_take;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      cs_rise |=> cmd_valid_reg && (word_reg == $past(link_word));
   endproperty
   a_cs_take: assert property (p_cs_take) else $error("word not taken at select rise");

   property p_no_cmd;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      cmd_valid_reg |=> !cmd_valid_reg;
   endproperty
   a_no_cmd: assert property (p_no_cmd) else $error("command pulse longer than one cycle");

   property p_load_only;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      (cmd_valid_reg && cmd_ctrl == qdac_pkg::CTRL_LOAD) |=>
         input_reg[$past(cmd_addr)] == $past(cmd_code) && conv_flat == $past(conv_flat);
   endproperty
   a_load_only: assert property (p_load_only) else $error("input load wrong or converter changed");

   property p_load_xfer;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      (cmd_valid_reg && cmd_ctrl == qdac_pkg::CTRL_LOAD_XFER) |=>
         conv_flat == input_flat && conv_reg[$past(cmd_addr)] == $past(cmd_code);
   endproperty
   a_load_xfer: assert property (p_load_xfer) else $error("load and transfer wrong");

   property p_update_wake;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      (cmd_valid_reg && cmd_op == qdac_pkg::OP_UPDATE_WAKE) |=>
         conv_flat == $past(input_flat) && !shutdown_reg && input_flat == $past(input_flat);
   endproperty
   a_update_wake: assert property (p_update_wake) else $error("update with wake wrong");

   property p_load_all;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      (cmd_valid_reg && cmd_op == qdac_pkg::OP_LOAD_ALL) |=>
         conv_a == $past(cmd_code) && conv_d == $past(cmd_code) && !shutdown_reg;
   endproperty
   a_load_all: assert property (p_load_all) else $error("broadcast load wrong");

   property p_sleep;
      @(posedge clk_sys) disable iff (!nrst || !clear_n || !shutdown_lockout_n)
      (cmd_valid_reg && cmd_op == qdac_pkg::OP_SHUTDOWN) |=>
         shutdown_reg == ($past(lock_sync) || $past(shutdown_reg));
   endproperty
   a_sleep: assert property (p_sleep) else $error("shutdown entry ignores lockout");

   property p_upo;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      (cmd_valid_reg && (cmd_op == qdac_pkg::OP_UPO_HIGH || cmd_op == qdac_pkg::OP_UPO_LOW)) |=>
         user_logic_out == ($past(cmd_op) == qdac_pkg::OP_UPO_HIGH);
   endproperty
   a_upo: assert property (p_upo) else $error("logic output wrong");

   property p_nop;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      (cmd_valid_reg && cmd_op == qdac_pkg::OP_NO_OPERATION) |=>
         conv_flat == $past(conv_flat) && input_flat == $past(input_flat) && $stable(shutdown_reg);
   endproperty
   a_nop: assert property (p_nop) else $error("no-operation changed state");

   property p_mode;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      (cmd_valid_reg && (cmd_op == qdac_pkg::OP_MODE1 || cmd_op == qdac_pkg::OP_MODE0)) |=>
         echo_mode == ($past(cmd_op) == qdac_pkg::OP_MODE1) && conv_flat == $past(input_flat)
         && $stable(shutdown_reg);
   endproperty
   a_mode: assert property (p_mode) else $error("echo mode command wrong");

   property p_idle_hold;
      @(posedge clk_sys) disable iff (!nrst || !clear_n)
      !cmd_valid_reg |=> input_flat == $past(input_flat) && conv_flat == $past(conv_flat);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("channel changed without command");

   property p_reset;
      @(posedge clk_sys)
      !nrst |=> conv_a == qdac_pkg::CODE_RESET && conv_c == qdac_pkg::CODE_RESET
         && echo_mode == qdac_pkg::MODE_RESET && !user_logic_out;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");

   property p_lock_wake;
      @(posedge clk_sys) disable iff (!nrst)
      !shutdown_lockout_n |-> !shutdown;
   endproperty
   a_lock_wake: assert property (p_lock_wake) else $error("shut down while lockout low");

   property p_clear;
      @(posedge clk_sys)
      !clear_n |-> conv_b == qdac_pkg::CODE_RESET && conv_d == qdac_pkg::CODE_RESET
         && !user_logic_out && link_word == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not zero state");

   c_load_xfer: cover property (@(posedge clk_sys) disable iff (!nrst)
      cmd_valid_reg && cmd_ctrl == qdac_pkg::CTRL_LOAD_XFER);
   c_sleep_wake: cover property (@(posedge clk_sys) disable iff (!nrst)
      $rose(shutdown_reg) ##[1:400] $fell(shutdown_reg));
   c_mode1: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(echo_mode_reg));
   c_upo_high: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(upo_reg));
endmodule

// File: tb/serial_host.sv
// Host model driving the converter's three-wire serial port
`timescale 1ns/100ps
module serial_host (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   logic [15:0] rx_lo;
   logic [15:0] rx_hi;
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      din = 1'h0;
      rx_lo = 16'h0000;
      rx_hi = 16'h0000;
   end
   ////////////////////////////////////////////////////////////
   // Top nbits of w, MSB first; split stalls the clock after eight bits
   task automatic send_word(input logic [15:0] w, input int nbits, input bit split);
      #13;
      cs_n = 1'h0;
      #40;
      for (int i = 0; i < nbits; i++) begin
         din = w[15-i];
         #15;
         sclk = 1'h1;
         #8;
         rx_hi = {rx_hi[14:0], dout};
         #8;
         sclk = 1'h0;
         #1;
         rx_lo = {rx_lo[14:0], dout};
         if (split && i == 7) begin
            #200;
         end
      end
      #40;
      cs_n = 1'h1;
      // Released line must not keep showing the last bit
      din = ~din;
   endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the quad converter serial command control
`timescale 1ns/100ps
module testbench;
   typedef struct packed {
      logic [15:0] word;
      logic [9:0] a;
      logic [9:0] b;
      logic [9:0] c;
      logic [9:0] d;
      logic [2:0] f;
   } row_t;
   logic clk_sys = 1'h0;
   logic nrst = 1'h0;
   logic clear_n = 1'h1;
   logic shutdown_lockout_n = 1'h1;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;
   logic [9:0] conv_a;
   logic [9:0] conv_b;
   logic [9:0] conv_c;
   logic [9:0] conv_d;
   logic user_logic_out;
   logic shutdown;
   logic echo_mode;
   int n_fail = 0;
   int total_checks = 0;
   row_t rows[$];
   always #50 clk_sys = ~clk_sys;
   quad_dac_serial_command_control i_dut (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
      .din(din), .clear_n(clear_n), .shutdown_lockout_n(shutdown_lockout_n), .dout(dout),
      .conv_a(conv_a), .conv_b(conv_b), .conv_c(conv_c), .conv_d(conv_d),
      .user_logic_out(user_logic_out), .shutdown(shutdown), .echo_mode(echo_mode));
   serial_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] mk(input logic [3:0] op, input logic [9:0] code);
      return {op, code, 2'h0};
   endfunction
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic check_outs(input row_t r);
      check("conv_a", {6'h0, conv_a}, {6'h0, r.a});
      check("conv_b", {6'h0, conv_b}, {6'h0, r.b});
      check("conv_c", {6'h0, conv_c}, {6'h0, r.c});
      check("conv_d", {6'h0, conv_d}, {6'h0, r.d});
      check("upo_shut_mode", {13'h0, user_logic_out, shutdown, echo_mode}, {13'h0, r.f});
   endtask
   // Fixed settle: decode lands within four system cycles after select rises
   task automatic send(input logic [15:0] w, input int n, input bit split);
      i_host.send_word(w, n, split);
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic add(input logic [3:0] op, input logic [9:0] code, input logic [9:0] a, input logic [9:0] b,
                      input logic [9:0] c, input logic [9:0] d, input logic [2:0] f);
      rows.push_back('{mk(op, code), a, b, c, d, f});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      $display("[FAIL] watchdog expected done seen hang");
      finish_test;
   end
   initial begin
      logic [15:0] w;
      logic [9:0] e;
      add(4'h1, 10'h155, 10'h000, 10'h000, 10'h000, 10'h000, 3'h0);
      add(4'h5, 10'h2aa, 10'h000, 10'h000, 10'h000, 10'h000, 3'h0);
      add(4'h9, 10'h3ff, 10'h000, 10'h000, 10'h000, 10'h000, 3'h0);
      add(4'hd, 10'h001, 10'h000, 10'h000, 10'h000, 10'h000, 3'h0);
      add(4'h0, 10'h123, 10'h000, 10'h000, 10'h000, 10'h000, 3'h0);
      add(4'h4, 10'h000, 10'h155, 10'h2aa, 10'h3ff, 10'h001, 3'h0);
      add(4'h3, 10'h0f0, 10'h0f0, 10'h2aa, 10'h3ff, 10'h001, 3'h0);
      add(4'h6, 10'h000, 10'h0f0, 10'h2aa, 10'h3ff, 10'h001, 3'h4);
      add(4'hc, 10'h000, 10'h0f0, 10'h2aa, 10'h3ff, 10'h001, 3'h6);
      add(4'h7, 10'h200, 10'h0f0, 10'h200, 10'h3ff, 10'h001, 3'h6);
      add(4'h4, 10'h000, 10'h0f0, 10'h200, 10'h3ff, 10'h001, 3'h4);
      add(4'h2, 10'h000, 10'h0f0, 10'h200, 10'h3ff, 10'h001, 3'h0);
      add(4'hc, 10'h000, 10'h0f0, 10'h200, 10'h3ff, 10'h001, 3'h2);
      add(4'h8, 10'h2cc, 10'h2cc, 10'h2cc, 10'h2cc, 10'h2cc, 3'h0);
      add(4'h1, 10'h3a5, 10'h2cc, 10'h2cc, 10'h2cc, 10'h2cc, 3'h0);
      add(4'he, 10'h000, 10'h3a5, 10'h2cc, 10'h2cc, 10'h2cc, 3'h1);
      add(4'h5, 10'h0c3, 10'h3a5, 10'h2cc, 10'h2cc, 10'h2cc, 3'h1);
      add(4'ha, 10'h000, 10'h3a5, 10'h0c3, 10'h2cc, 10'h2cc, 3'h0);
      // Clear needs a real falling edge, else the link-side flops stay unknown
      @(posedge clk_sys);
      clear_n <= 1'h0;
      repeat (15) @(posedge clk_sys);
      nrst <= 1'h1;
      clear_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
      check_outs('0);
      // Warm-up frame; a lost first bit still decodes as no operation
      send(16'h0000, 16, 1'b0);
      foreach (rows[i]) begin
         send(rows[i].word, 16, 1'b0);
         check_outs(rows[i]);
      end
      send(mk(4'h3, 10'h1e1), 16, 1'b1);
      check("split", {6'h0, conv_a}, 16'h01e1);
      send(16'h0083, 16, 1'b0);
      send(16'h5400, 8, 1'b0);
      w = 16'h8354;
      e = w[qdac_pkg::CODE_HI:qdac_pkg::CODE_LO];
      check("short_frame", {6'h0, conv_c}, {6'h0, e});
      @(posedge clk_sys);
      shutdown_lockout_n <= 1'h0;
      repeat (4) @(posedge clk_sys);
      send(mk(4'hc, 10'h000), 16, 1'b0);
      check("locked", {15'h0, shutdown}, 16'h0000);
      shutdown_lockout_n <= 1'h1;
      repeat (4) @(posedge clk_sys);
      send(mk(4'hc, 10'h000), 16, 1'b0);
      check("shut", {15'h0, shutdown}, 16'h0001);
      shutdown_lockout_n <= 1'h0;
      #1;
      check("async_wake", {15'h0, shutdown}, 16'h0000);
      check("restored", {6'h0, conv_a}, {6'h0, e});
      @(posedge clk_sys);
      shutdown_lockout_n <= 1'h1;
      send(16'h0abc, 16, 1'b0);
      send(16'h0000, 16, 1'b0);
      check("echo0_lo", i_host.rx_lo, 16'h0abc);
      check("echo0_hi", {1'h0, i_host.rx_hi[14:0]}, 16'h055e);
      send(mk(4'he, 10'h000), 16, 1'b0);
      send(16'h0abc, 16, 1'b0);
      send(16'h0000, 16, 1'b0);
      check("echo1_hi", i_host.rx_hi, 16'h0abc);
      check("echo1_lo", i_host.rx_lo, 16'h0abc);
      send(mk(4'h6, 10'h000), 16, 1'b0);
      clear_n <= 1'h0;
      #1;
      check("clr_conv", {6'h0, conv_d}, 16'h0000);
      check("clr_flags", {13'h0, user_logic_out, shutdown, echo_mode}, 16'h0000);
      @(posedge clk_sys);
      clear_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
      send(16'h0ff0, 16, 1'b0);
      check("clr_shift", i_host.rx_lo, 16'h0000);
      finish_test;
   end
endmodule
